// file: src/current_adc_frontend_clocking.sv
`timescale 1ns/1ps
`default_nettype none
module current_adc_frontend_clocking import cafe_pkg::*; #(
    parameter int IN_W = 20
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Wishbone slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_wr,
    output logic [31:0] wb_dat_rd,
    output logic wb_ack,
    // External main clock pin
    input wire logic ext_clk_pin,
    // Channel inputs: shunt_sample index 0 is section A, test_signal index 0 feeds section B
    input wire logic signed [IN_W-1:0] shunt_sample [2],
    input wire logic signed [IN_W-1:0] test_signal [2],
    // Channel outputs
    output sw_t sw_a,
    output sw_t sw_b,
    output logic [1:0] mod_bit,
    output logic mod_valid,
    output logic mod_clk,
    output logic [1:0] overcurrent,
    output logic clk_source_active
);
    // ************************************************************
    // Register file
    // ************************************************************
    logic clk_src_q, clk_src_d;
    logic [1:0] conv_en_q, conv_en_d;
    ch_cfg_t cfg_q [2];
    ch_cfg_t cfg_d [2];
    logic [23:0] oc_thr_q, oc_thr_d;
    logic [31:0] rd_q, rd_d;
    logic ack_q, ack_d;
    src_state_t state_q, state_d;
    logic [1:0] oc_q;

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] fsr_nv(input gain_t g);
        case (g)
            GAIN_4: return FSR_G4_NV;
            GAIN_8: return FSR_G8_NV;
            GAIN_16: return FSR_G16_NV;
            default: return FSR_G32_NV;
        endcase
    endfunction

    always_comb begin
        logic [31:0] m;
        m = '0;
        clk_src_d = clk_src_q;
        conv_en_d = conv_en_q;
        cfg_d = cfg_q;
        oc_thr_d = oc_thr_q;
        rd_d = rd_q;
        ack_d = wb_cyc && wb_stb && !ack_q;
        if (ack_d) begin
            rd_d = '0;
            case (wb_adr)
                ADR_CLK_CTRL: rd_d = {29'h0, conv_en_q, clk_src_q};
                ADR_CFG_A: rd_d = {28'h0, cfg_q[0]};
                ADR_CFG_B: rd_d = {28'h0, cfg_q[1]};
                ADR_STATUS: rd_d = {28'h0, oc_q, (state_q == ST_TO_EXT || state_q == ST_TO_INT),
                                    clk_source_active};
                ADR_OC_THR: rd_d = {8'h0, oc_thr_q};
                ADR_FSR_A: rd_d = fsr_nv(cfg_q[0].gain);
                ADR_FSR_B: rd_d = fsr_nv(cfg_q[1].gain);
                default: rd_d = '0;
            endcase
            if (wb_we) begin
                case (wb_adr)
                    ADR_CLK_CTRL: begin
                        m = wmerge({29'h0, conv_en_q, clk_src_q}, wb_dat_wr, wb_sel);
                        clk_src_d = m[CTRL_SRC_BIT];
                        conv_en_d = m[CTRL_EN_LSB +: 2];
                    end
                    ADR_CFG_A: begin
                        m = wmerge({28'h0, cfg_q[0]}, wb_dat_wr, wb_sel);
                        cfg_d[0] = ch_cfg_t'(m[3:0]);
                    end
                    ADR_CFG_B: begin
                        m = wmerge({28'h0, cfg_q[1]}, wb_dat_wr, wb_sel);
                        cfg_d[1] = ch_cfg_t'(m[3:0]);
                    end
                    ADR_OC_THR: begin
                        m = wmerge({8'h0, oc_thr_q}, wb_dat_wr, wb_sel);
                        oc_thr_d = m[23:0];
                    end
                    default: m = '0;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            clk_src_q <= CLK_SRC_RST;
            conv_en_q <= CONV_EN_RST;
            cfg_q[0] <= ch_cfg_t'(CFG_RST);
            cfg_q[1] <= ch_cfg_t'(CFG_RST);
            oc_thr_q <= OC_THR_RST;
            rd_q <= '0;
            ack_q <= 1'h0;
        end else begin
            clk_src_q <= clk_src_d;
            conv_en_q <= conv_en_d;
            cfg_q <= cfg_d;
            oc_thr_q <= oc_thr_d;
            rd_q <= rd_d;
            ack_q <= ack_d;
        end
    end

    assign wb_dat_rd = rd_q;
    assign wb_ack = ack_q;

    // ************************************************************
    // Main clock selection and modulator divider
    // ************************************************************
    logic ext_s1_q, ext_s2_q, ext_s3_q;
    logic ext_edge;
    logic [31:0] nco_q, nco_d;
    logic nco_carry;
    logic mclk_tick, mod_tick;
    logic mod_clk_q, mod_clk_d;
    logic active_q, active_d;

    assign ext_edge = ext_s2_q && !ext_s3_q;
    assign mclk_tick = (state_q == ST_RUN_EXT || state_q == ST_TO_INT) ? ext_edge : nco_carry;
    assign mod_tick = mclk_tick && !mod_clk_q;

    always_comb begin
        {nco_carry, nco_d} = {1'h0, nco_q} + {1'h0, NCO_INC};
        state_d = state_q;
        case (state_q)
            ST_RUN_INT: if (clk_src_q) state_d = ST_TO_EXT;
            ST_TO_EXT: begin
                if (!clk_src_q) begin
                    state_d = ST_RUN_INT;
                end else if (ext_edge) begin
                    state_d = ST_RUN_EXT;
                end
            end
            ST_RUN_EXT: if (!clk_src_q) state_d = ST_TO_INT;
            ST_TO_INT: if (ext_edge) state_d = ST_RUN_INT;
            default: state_d = ST_RUN_INT;
        endcase
        active_d = (state_d == ST_RUN_EXT || state_d == ST_TO_INT);
        mod_clk_d = mclk_tick ? !mod_clk_q : mod_clk_q;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ext_s1_q <= 1'h0;
            ext_s2_q <= 1'h0;
            ext_s3_q <= 1'h0;
            nco_q <= '0;
            state_q <= ST_RUN_INT;
            active_q <= 1'h0;
            mod_clk_q <= 1'h0;
        end else begin
            ext_s1_q <= ext_clk_pin;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            nco_q <= nco_d;
            state_q <= state_d;
            active_q <= active_d;
            mod_clk_q <= mod_clk_d;
        end
    end

    assign mod_clk = mod_clk_q;
    assign clk_source_active = active_q;

    // ************************************************************
    // Channels
    // ************************************************************
    logic signed [31:0] scaled [2];
    logic signed [31:0] int1_q [2];
    logic signed [31:0] int2_q [2];
    logic [1:0] bit_q;
    logic valid_q;

    generate
        for (genvar c = 0; c < 2; c++) begin : g_ch
            logic signed [31:0] x, g, fb, i1_d, i2_d;
            logic oc_d;
            always_comb begin
                case (cfg_q[c].sel)
                    SEL_DIRECT: x = 32'(shunt_sample[c]);
                    SEL_INVERT: x = -32'(shunt_sample[c]);
                    SEL_SHORT: x = '0;
                    default: x = 32'(test_signal[1-c]);
                endcase
                g = x <<< (32'(cfg_q[c].gain) + 32'h2);
                if (g > FS_POS) begin
                    scaled[c] = FS_POS;
                end else if (g < FS_NEG) begin
                    scaled[c] = FS_NEG;
                end else begin
                    scaled[c] = g;
                end
                fb = bit_q[c] ? DSM_REF : -DSM_REF;
                i1_d = int1_q[c] + scaled[c] - fb;
                i2_d = int2_q[c] + i1_d - fb;
                oc_d = (scaled[c] < 0 ? -scaled[c] : scaled[c]) > $signed({8'h0, oc_thr_q});
            end
            always_ff @(posedge ref_clk) begin
                if (rst || !conv_en_q[c]) begin
                    int1_q[c] <= '0;
                    int2_q[c] <= '0;
                    bit_q[c] <= 1'h0;
                    oc_q[c] <= 1'h0;
                end else if (mod_tick) begin
                    int1_q[c] <= i1_d;
                    int2_q[c] <= i2_d;
                    bit_q[c] <= !i2_d[31];
                    oc_q[c] <= oc_d;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            valid_q <= 1'h0;
        end else begin
            valid_q <= mod_tick && (conv_en_q != 2'h0);
        end
    end

    assign mod_bit = bit_q;
    assign mod_valid = valid_q;
    assign overcurrent = oc_q;

    input_switch_ctrl u_sw_a (.ref_clk(ref_clk), .rst(rst), .sel(cfg_q[0].sel), .sw_q(sw_a));
    input_switch_ctrl u_sw_b (.ref_clk(ref_clk), .rst(rst), .sel(cfg_q[1].sel), .sw_q(sw_b));

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_to_ext_edge;
        state_q == ST_TO_EXT && clk_src_q && ext_edge;
    endsequence
    AST_RESET_INTERNAL: assert property ($past(rst) |-> state_q == ST_RUN_INT && !clk_source_active)
        else $error("source not internal after reset");
    AST_EXT_TAKEOVER: assert property (s_to_ext_edge |=> state_q == ST_RUN_EXT && clk_source_active)
        else $error("external source not taken on its edge");
    AST_INT_RETURN: assert property (state_q == ST_TO_INT && ext_edge
        |=> state_q == ST_RUN_INT && !clk_source_active)
        else $error("internal source not restored");
    AST_MOD_TOGGLE: assert property (mclk_tick |=> mod_clk_q != $past(mod_clk_q))
        else $error("modulator clock missed a main clock tick");
    AST_MOD_HOLD: assert property (!mclk_tick |=> $stable(mod_clk_q))
        else $error("modulator clock moved without a tick");
    AST_SIM_VALID: assert property (mod_tick && conv_en_q == 2'h3 |=> mod_valid ##1 !mod_valid)
        else $error("modulator valid is not a single pulse");
    AST_SW_SHORT: assert property ($stable(cfg_q[0]) && cfg_q[0].sel == SEL_SHORT |=> sw_a == sw_t'(5'h0C))
        else $error("short setting drives wrong switches");
    AST_SW_TEST: assert property ($stable(cfg_q[1]) && cfg_q[1].sel == SEL_TEST |=> sw_b == sw_t'(5'h05))
        else $error("test setting drives wrong switches");
    AST_SHORT_ZERO: assert property (cfg_q[0].sel == SEL_SHORT |-> scaled[0] == 0)
        else $error("shorted input is not zero");
    AST_GAIN32: assert property (cfg_q[1].gain == GAIN_32 && cfg_q[1].sel == SEL_DIRECT
                                 && 32'(shunt_sample[1]) < 32'sh0000_4000 && 32'(shunt_sample[1]) > -32'sh0000_4000
                                 |-> scaled[1] == 32'(shunt_sample[1]) * 32)
        else $error("gain 32 scaling wrong");
    AST_OC_FLAG: assert property (mod_tick && conv_en_q[0] && scaled[0] > $signed({8'h0, oc_thr_q})
        |=> overcurrent[0])
        else $error("overcurrent not flagged");
endmodule
`default_nettype wire

// file: common/cafe_pkg.sv
// ************************************************************
// Shared constants and types
// ************************************************************
package cafe_pkg;
    // Register offsets
    localparam logic [7:0] ADR_CLK_CTRL = 8'h00;
    localparam logic [7:0] ADR_CFG_A = 8'h04;
    localparam logic [7:0] ADR_CFG_B = 8'h08;
    localparam logic [7:0] ADR_STATUS = 8'h0C;
    localparam logic [7:0] ADR_OC_THR = 8'h10;
    localparam logic [7:0] ADR_FSR_A = 8'h14;
    localparam logic [7:0] ADR_FSR_B = 8'h18;
    // Field positions
    localparam int CTRL_SRC_BIT = 0;
    localparam int CTRL_EN_LSB = 1;
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_OC_LSB = 2;
    // Reset values
    localparam logic CLK_SRC_RST = 1'h0;
    localparam logic [1:0] CONV_EN_RST = 2'h0;
    localparam logic [3:0] CFG_RST = 4'h0;
    localparam logic [23:0] OC_THR_RST = 24'h7F_FFFF;
    // Timing
    localparam logic [63:0] REF_CLK_HZ = 64'h0000_0000_05F5_E100;
    localparam logic [63:0] OSC_HZ = 64'h0000_0000_007D_0000;
    localparam logic [31:0] NCO_INC = 32'((OSC_HZ << 32) / REF_CLK_HZ);
    // Converter scaling
    localparam int ADC_W = 24;
    localparam logic signed [31:0] FS_POS = 32'sh007F_FFFF;
    localparam logic signed [31:0] FS_NEG = -32'sh0080_0000;
    localparam logic signed [31:0] DSM_REF = 32'sh0080_0000;
    // Full-scale range per gain in nanovolts
    localparam logic [31:0] FSR_G4_NV = 32'h12A0_5F20;
    localparam logic [31:0] FSR_G8_NV = 32'h0950_2F90;
    localparam logic [31:0] FSR_G16_NV = 32'h04A8_17C8;
    localparam logic [31:0] FSR_G32_NV = 32'h0254_0DD8;

    typedef enum logic [1:0] {
        SEL_DIRECT = 2'h0,
        SEL_INVERT = 2'h1,
        SEL_SHORT = 2'h2,
        SEL_TEST = 2'h3
    } in_sel_t;

    typedef enum logic [1:0] {
        GAIN_4 = 2'h0,
        GAIN_8 = 2'h1,
        GAIN_16 = 2'h2,
        GAIN_32 = 2'h3
    } gain_t;

    typedef struct packed {
        gain_t gain;
        in_sel_t sel;
    } ch_cfg_t;

    typedef struct packed {
        logic sw_direct_path;
        logic sw_ground_short;
        logic sw_reference_leg;
        logic sw_inverted_leg;
        logic sw_test_signal;
    } sw_t;

    typedef enum logic [1:0] {
        ST_RUN_INT = 2'h0,
        ST_TO_EXT = 2'h1,
        ST_RUN_EXT = 2'h3,
        ST_TO_INT = 2'h2
    } src_state_t;
endpackage

// file: src/input_switch_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Input switch driver for one channel
// ************************************************************
module input_switch_ctrl import cafe_pkg::*; (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Selection and switches
    input wire in_sel_t sel,
    output sw_t sw_q
);
    sw_t sw_d;

    always_comb begin
        sw_d = '0;
        case (sel)
            SEL_DIRECT: begin
                sw_d.sw_direct_path = 1'h1;
                sw_d.sw_reference_leg = 1'h1;
            end
            SEL_INVERT: begin
                sw_d.sw_direct_path = 1'h1;
                sw_d.sw_inverted_leg = 1'h1;
            end
            SEL_SHORT: begin
                sw_d.sw_ground_short = 1'h1;
                sw_d.sw_reference_leg = 1'h1;
            end
            SEL_TEST: begin
                sw_d.sw_reference_leg = 1'h1;
                sw_d.sw_test_signal = 1'h1;
            end
            default: sw_d = '0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sw_q <= '0;
        end else begin
            sw_q <= sw_d;
        end
    end
endmodule
`default_nettype wire

// file: dv/ext_clock_source.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// External main clock source
// ************************************************************
module ext_clock_source #(
    parameter real HALF_NS = 48.5
) (
    // Control from the bench
    input wire logic run,
    // Clock pin
    output logic clk_pin
);
    initial clk_pin = 1'b0;
    // Toggles only while run is high, rests low otherwise
    always begin
        #(HALF_NS);
        clk_pin = run ? ~clk_pin : 1'b0;
    end
endmodule
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import cafe_pkg::*;;
    logic ref_clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, ext_clk_pin, ext_run;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_wr, wb_dat_rd, rd;
    logic signed [19:0] shunt_sample [2];
    logic signed [19:0] test_signal [2];
    sw_t sw_a, sw_b;
    logic [1:0] mod_bit, overcurrent;
    logic mod_valid, mod_clk, clk_source_active;
    logic [15:0] seed;
    int errors, total_checks, rises, highs, valids, ones;

    current_adc_frontend_clocking #(.IN_W(20)) dut (.ref_clk(ref_clk), .rst(rst), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_wr(wb_dat_wr),
        .wb_dat_rd(wb_dat_rd), .wb_ack(wb_ack), .ext_clk_pin(ext_clk_pin), .shunt_sample(shunt_sample),
        .test_signal(test_signal), .sw_a(sw_a), .sw_b(sw_b), .mod_bit(mod_bit), .mod_valid(mod_valid),
        .mod_clk(mod_clk), .overcurrent(overcurrent), .clk_source_active(clk_source_active));
    ext_clock_source #(.HALF_NS(48.5)) partner (.run(ext_run), .clk_pin(ext_clk_pin));

    always #5 ref_clk = ~ref_clk;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic sw_t exp_sw(input logic [1:0] s);
        sw_t w;
        w.sw_direct_path = (s <= 2'h1);
        w.sw_ground_short = (s == 2'h2);
        w.sw_reference_leg = (s != 2'h1);
        w.sw_inverted_leg = (s == 2'h1);
        w.sw_test_signal = (s == 2'h3);
        return w;
    endfunction
    function automatic logic [31:0] exp_fsr(input logic [1:0] g);
        case (g)
            2'h0: return 32'h12A0_5F20;
            2'h1: return 32'h0950_2F90;
            2'h2: return 32'h04A8_17C8;
            default: return 32'h0254_0DD8;
        endcase
    endfunction
    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic check_near(input string name, input int exp, input int got, input int tol);
        total_checks++;
        if (got > exp + tol || got < exp - tol) begin
            errors++;
            $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
        end
    endtask
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_sel <= 4'hF;
        wb_adr <= adr;
        wb_dat_wr <= wd;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (wb_ack !== 1'b1) begin
            errors++;
            $display("[FAIL] wb_ack expected 1 seen timeout");
        end
        rd = wb_dat_rd;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic measure();
        logic last;
        rises = 0;
        highs = 0;
        valids = 0;
        ones = 0;
        last = mod_clk;
        repeat (2000) begin
            @(posedge ref_clk);
            rises += (mod_clk === 1'b1 && last === 1'b0);
            highs += (mod_clk === 1'b1);
            valids += (mod_valid === 1'b1);
            ones += (mod_valid === 1'b1 && mod_bit[0] === 1'b1) + (mod_valid === 1'b1 && mod_bit[1] === 1'b1);
            last = mod_clk;
        end
    endtask
    task automatic wait_oc(input logic [1:0] exp);
        int n;
        n = 0;
        while (overcurrent !== exp && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        check_val("overcurrent", 32'(exp), 32'(overcurrent));
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        ref_clk = 1'b0;
        rst = 1'b1;
        {wb_cyc, wb_stb, wb_we, ext_run} = 4'h0;
        wb_adr = 8'h00;
        wb_sel = 4'hF;
        wb_dat_wr = 32'h0;
        shunt_sample = '{20'sh0, 20'sh0};
        test_signal = '{20'sh0, 20'sh0};
        seed = 16'h0039;
        errors = 0;
        total_checks = 0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check_val("clk_source_active", 32'h0, 32'(clk_source_active));
        check_val("sw_a", 32'(exp_sw(2'h0)), 32'(sw_a));
        wb_xfer(1'b0, ADR_CLK_CTRL, 32'h0);
        check_val("clk_ctrl", 32'h0, rd);
        wb_xfer(1'b0, 8'h1C, 32'h0);
        check_val("unmapped", 32'h0, rd);
        $display("test reset done");
        for (int s = 0; s < 4; s++) begin
            seed = lfsr(seed);
            wb_xfer(1'b1, ADR_CFG_A, {28'h0, seed[1:0], 2'(s)});
            wb_xfer(1'b1, ADR_CFG_B, {28'h0, seed[3:2], 2'(3 - s)});
            @(posedge ref_clk);
            check_val("sw_a", 32'(exp_sw(2'(s))), 32'(sw_a));
            check_val("sw_b", 32'(exp_sw(2'(3 - s))), 32'(sw_b));
            wb_xfer(1'b0, ADR_FSR_A, 32'h0);
            check_val("fsr_a", exp_fsr(seed[1:0]), rd);
            wb_xfer(1'b0, ADR_FSR_B, 32'h0);
            check_val("fsr_b", exp_fsr(seed[3:2]), rd);
        end
        $display("test select and gain done");
        wb_xfer(1'b1, ADR_OC_THR, 32'h0000_03E8);
        wb_xfer(1'b1, ADR_CLK_CTRL, 32'h0000_0006);
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 4; s++) begin
                seed = lfsr(seed);
                shunt_sample[0] <= p ? 20'sh0 : 20'sh01000 + 20'(seed[11:0]);
                shunt_sample[1] <= p ? 20'sh0 : -20'sh01000 - 20'(seed[11:0]);
                test_signal[0] <= p ? 20'sh02000 : 20'sh0;
                test_signal[1] <= p ? 20'sh0 : 20'sh02000;
                wb_xfer(1'b1, ADR_CFG_A, {28'h0, seed[13:12], 2'(s)});
                wb_xfer(1'b1, ADR_CFG_B, {28'h0, 2'(3 - s), 2'(s)});
                wait_oc(p ? {s == 3, 1'b0} : {s < 2, s != 2});
            end
        end
        $display("test overcurrent done");
        measure();
        check_near("mod_clk rises int", 82, rises, 1);
        check_near("mod_clk high", 1000, highs, 30);
        check_near("mod_valid", rises, valids, 2);
        check_near("mod_bit ones", 82, ones, 4);
        wb_xfer(1'b1, ADR_CLK_CTRL, 32'h0);
        measure();
        check_val("mod_valid off", 32'h0, 32'(valids));
        ext_run <= 1'b1;
        wb_xfer(1'b1, ADR_CLK_CTRL, 32'h1);
        for (int n = 0; n < 200 && clk_source_active !== 1'b1; n++) @(posedge ref_clk);
        check_val("clk_source_active", 32'h1, 32'(clk_source_active));
        wb_xfer(1'b0, ADR_STATUS, 32'h0);
        check_val("status active", 32'h1, 32'(rd[STAT_ACTIVE_BIT]));
        measure();
        check_near("mod_clk rises ext", 103, rises, 1);
        check_near("mod_clk high ext", 1000, highs, 30);
        wb_xfer(1'b1, ADR_CLK_CTRL, 32'h0);
        for (int n = 0; n < 200 && clk_source_active !== 1'b0; n++) @(posedge ref_clk);
        check_val("clk_source_active", 32'h0, 32'(clk_source_active));
        wb_xfer(1'b1, ADR_CLK_CTRL, 32'h1);
        for (int n = 0; n < 200 && clk_source_active !== 1'b1; n++) @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check_val("clk_source_active", 32'h0, 32'(clk_source_active));
        wb_xfer(1'b0, ADR_CLK_CTRL, 32'h0);
        check_val("clk_ctrl", 32'h0, rd);
        ext_run <= 1'b0;
        measure();
        check_near("mod_clk rises int", 82, rises, 1);
        $display("test clock source done");
        stop_test();
    end

    initial begin
        repeat (60000) @(posedge ref_clk);
        errors++;
        $display("[FAIL] run expected end seen timeout");
        stop_test();
    end
endmodule
`default_nettype wire
